/* sfc_pkg.sv */
/*
  Constants, register map and state types of the serial FIFO configuration
  block. Assumes a single 25 MHz clock domain and a plain register port.
*/
// Contract
// - FIFO is used only while the enable bit 0 is one.
// - Enabled FIFO sized by duplex: 4 RX, 4 TX, or 2 plus 2.
// - Sizing follows the duplex selection automatically, no extra software step.
// - Usage select bit 4 picks full RX size or the RX fill level.
// - TX FIFO always offers its full configured capacity.
// - With FIFO on, TX FIFO interrupts pass only when bit 3 is one.
// - With FIFO on, RX FIFO interrupts pass only when bit 2 is one.
// - Auto disable, half RX: clear RX enable when shift, buffer, FIFO full.
// - Auto disable, half TX: clear TX enable when FIFO, buffer, shift empty.
// - Auto disable, full duplex: either condition clears both enables.
// - Without auto disable, enables are never cleared by this block.
// - RX fill code: half 4,1,2,3 bytes; full 2,1,2,1 bytes.
package sfc_pkg;

  // ==========================================================
  // Register port
  localparam int unsigned ADDR_W      = 8;
  localparam logic [7:0]  ADDR_FCNF   = 8'h00; // fifo_configuration
  localparam logic [7:0]  ADDR_ISTS   = 8'h04; // Event status, write one to clear
  localparam logic [7:0]  ADDR_IMSK   = 8'h08; // Event mask
  localparam logic [7:0]  ADDR_STATE  = 8'h0C; // Read-only sizing state
  localparam logic [7:0]  FCNF_RESET  = 8'h00;
  localparam logic [3:0]  IMSK_RESET  = 4'h0;

  // ==========================================================
  // fifo_configuration fields
  localparam int unsigned BIT_FIFO_EN   = 0;
  localparam int unsigned BIT_AUTO_DIS  = 1;
  localparam int unsigned BIT_RX_IRQ_EN = 2;
  localparam int unsigned BIT_TX_IRQ_EN = 3;
  localparam int unsigned BIT_RX_USE    = 4;

  // ==========================================================
  // Duplex selection from mode_control_one
  localparam logic [1:0] DPX_HALF_RX = 2'h1;
  localparam logic [1:0] DPX_HALF_TX = 2'h2;
  localparam logic [1:0] DPX_FULL    = 2'h3;

  // ==========================================================
  // FIFO sizes in bytes
  localparam logic [2:0] SIZE_NONE = 3'h0;
  localparam logic [2:0] SIZE_HALF = 3'h4;
  localparam logic [2:0] SIZE_FULL = 3'h2;

  // ==========================================================
  // Event bits of the status and mask registers
  localparam int unsigned NUM_EV     = 4;
  localparam int unsigned EV_RX_STOP = 0;
  localparam int unsigned EV_TX_STOP = 1;
  localparam int unsigned EV_TX_FIFO = 2;
  localparam int unsigned EV_RX_FIFO = 3;

  // ==========================================================
  // Auto disable sequencer
  typedef enum logic [2:0] {
    SFC_AD_IDLE  = 3'b001,
    SFC_AD_CLEAR = 3'b010,
    SFC_AD_HOLD  = 3'b100
  } sfc_ad_state_t;

endpackage

/* sfc_size_decode.sv */
/*
  Combinational FIFO sizing: configured RX and TX sizes and the RX usage
  limit. Assumes duplex and fill code come from same-clock registers.
*/
`timescale 1ns/100ps
module sfc_size_decode (
  input  wire logic       fifo_en,
  input  wire logic [1:0] duplex,
  input  wire logic [1:0] rx_fill_code,
  input  wire logic       rx_fifo_usage_select,
  output logic      [2:0] rx_size,
  output logic      [2:0] tx_size,
  output logic      [2:0] rx_limit
);

  // Fill code meaning depends on the duplex split
  function automatic logic [2:0] fill_bytes(input logic full, input logic [1:0] code);
    logic [2:0] r;
    r = sfc_pkg::SIZE_NONE;
    case (code)
      2'h0:    r = full ? sfc_pkg::SIZE_FULL : sfc_pkg::SIZE_HALF;
      2'h1:    r = 3'h1;
      2'h2:    r = 3'h2;
      default: r = full ? 3'h1 : 3'h3;
    endcase
    return r;
  endfunction

  wire logic is_full   = (duplex == sfc_pkg::DPX_FULL);
  wire logic is_half_r = (duplex == sfc_pkg::DPX_HALF_RX);
  wire logic is_half_t = (duplex == sfc_pkg::DPX_HALF_TX);
  wire logic [2:0] fill = fill_bytes(is_full, rx_fill_code);

  // Split follows duplex whenever the FIFO is on
  assign rx_size  = !fifo_en  ? sfc_pkg::SIZE_NONE :
                    is_half_r ? sfc_pkg::SIZE_HALF :
                    is_full   ? sfc_pkg::SIZE_FULL : sfc_pkg::SIZE_NONE;
  assign tx_size  = !fifo_en  ? sfc_pkg::SIZE_NONE :
                    is_half_t ? sfc_pkg::SIZE_HALF :
                    is_full   ? sfc_pkg::SIZE_FULL : sfc_pkg::SIZE_NONE;
  // Limit never exceeds the configured size
  assign rx_limit = (rx_fifo_usage_select && rx_size != sfc_pkg::SIZE_NONE) ? fill : rx_size;

endmodule

/* sfc_event_regs.sv */
/*
  Sticky event status with write-one-to-clear, mask and one level
  interrupt. Assumes event inputs are one-cycle pulses on ref_clk.
*/
`timescale 1ns/100ps
module sfc_event_regs (
  input  wire logic                        ref_clk,
  input  wire logic                        rstn,
  input  wire logic [sfc_pkg::NUM_EV-1:0]  event_set,
  input  wire logic                        status_wr,
  input  wire logic                        mask_wr,
  input  wire logic [sfc_pkg::NUM_EV-1:0]  wdata,
  output logic      [sfc_pkg::NUM_EV-1:0]  status,
  output logic      [sfc_pkg::NUM_EV-1:0]  mask,
  output logic                             irq
);

  logic [sfc_pkg::NUM_EV-1:0] status_ff;
  logic [sfc_pkg::NUM_EV-1:0] mask_ff;
  wire  logic [sfc_pkg::NUM_EV-1:0] clr = status_wr ? wdata : '0;

  // A set in the clearing cycle wins, so no event is lost
  genvar i;
  generate
    for (i = 0; i < sfc_pkg::NUM_EV; i++) begin : g_bit
      always_ff @(posedge ref_clk) begin
        if (!rstn) begin
          status_ff[i] <= 1'b0;
        end else begin
          status_ff[i] <= event_set[i] | (status_ff[i] & ~clr[i]);
        end
      end
    end
  endgenerate

  // Mask register
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      mask_ff <= sfc_pkg::IMSK_RESET;
    end else if (mask_wr) begin
      mask_ff <= wdata;
    end
  end

  assign status = status_ff;
  assign mask   = mask_ff;
  assign irq    = |(status_ff & mask_ff);

endmodule

/* sfc_fifo_config.sv */
/*
  Top of the serial FIFO configuration block: register port, FIFO sizing,
  FIFO interrupt gating and automatic receive/transmit disable.
  Assumes all channel inputs come from logic on ref_clk, so none are
  synchronised, and that software keeps the FIFO off where unsupported.
*/
// The address-and-strobe port and the address map are this design's own decisions.
`timescale 1ns/100ps
module sfc_fifo_config (
  input  wire logic                        ref_clk,
  input  wire logic                        rstn,
  // Register port
  input  wire logic [sfc_pkg::ADDR_W-1:0]  reg_addr,
  input  wire logic [31:0]                 reg_wdata,
  input  wire logic                        reg_wr,
  input  wire logic                        reg_rd,
  output logic      [31:0]                 reg_rdata,
  // Channel mode and fill code
  input  wire logic [1:0]                  duplex,
  input  wire logic [1:0]                  rx_fill_code,
  // Current enables of the channel
  input  wire logic                        rx_enable,
  input  wire logic                        tx_enable,
  // Receive path fullness
  input  wire logic                        rx_shift_full,
  input  wire logic                        rx_buf_full,
  input  wire logic                        rx_fifo_full,
  // Transmit path emptiness
  input  wire logic                        tx_fifo_empty,
  input  wire logic                        tx_buf_empty,
  input  wire logic                        tx_shift_empty,
  // Raw interrupt requests
  input  wire logic                        tx_fifo_irq_req,
  input  wire logic                        rx_fifo_irq_req,
  input  wire logic                        tx_buf_irq_req,
  input  wire logic                        rx_buf_irq_req,
  // Configuration towards the FIFOs
  output logic                             fifo_en,
  output logic      [2:0]                  rx_fifo_size,
  output logic      [2:0]                  tx_fifo_size,
  output logic      [2:0]                  rx_fifo_limit,
  // Channel interrupts after gating
  output logic                             tx_irq,
  output logic                             rx_irq,
  // One-cycle requests to drop the enables
  output logic                             rx_enable_clear,
  output logic                             tx_enable_clear,
  // Summary interrupt of this block
  output logic                             irq
);

  // ==========================================================
  // Register state

  logic [7:0]                 fcnf_ff;
  logic [31:0]                rdata_ff;
  logic [2:0]                 rx_size_ff;
  logic [2:0]                 tx_size_ff;
  logic [2:0]                 rx_limit_ff;
  logic                       tx_irq_ff;
  logic                       rx_irq_ff;
  logic                       rx_clr_ff;
  logic                       tx_clr_ff;
  sfc_pkg::sfc_ad_state_t     ad_state_ff;
  sfc_pkg::sfc_ad_state_t     nxt_ad_state;
  logic [31:0]                nxt_rdata;

  // ==========================================================
  // Address decode

  wire logic hit_fcnf  = (reg_addr == sfc_pkg::ADDR_FCNF);
  wire logic hit_ists  = (reg_addr == sfc_pkg::ADDR_ISTS);
  wire logic hit_imsk  = (reg_addr == sfc_pkg::ADDR_IMSK);
  wire logic hit_state = (reg_addr == sfc_pkg::ADDR_STATE);

  wire logic wr_fcnf = reg_wr & hit_fcnf;
  wire logic wr_ists = reg_wr & hit_ists;
  wire logic wr_imsk = reg_wr & hit_imsk;

  // ==========================================================
  // Configuration fields

  wire logic cfg_fifo_en  = fcnf_ff[sfc_pkg::BIT_FIFO_EN];
  wire logic cfg_auto_dis = fcnf_ff[sfc_pkg::BIT_AUTO_DIS];
  wire logic cfg_rx_irqen = fcnf_ff[sfc_pkg::BIT_RX_IRQ_EN];
  wire logic cfg_tx_irqen = fcnf_ff[sfc_pkg::BIT_TX_IRQ_EN];
  wire logic cfg_rx_use   = fcnf_ff[sfc_pkg::BIT_RX_USE];

  // Configuration register; bits 7 to 5 are kept as written
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      fcnf_ff <= sfc_pkg::FCNF_RESET;
    end else if (wr_fcnf) begin
      fcnf_ff <= reg_wdata[7:0];
    end
  end

  // ==========================================================
  // FIFO sizing

  wire logic [2:0] rx_size_c;
  wire logic [2:0] tx_size_c;
  wire logic [2:0] rx_limit_c;

  // Sizes recomputed every cycle from live duplex, no software step
  sfc_size_decode u_size (
    .fifo_en              (cfg_fifo_en),
    .duplex               (duplex),
    .rx_fill_code         (rx_fill_code),
    .rx_fifo_usage_select (cfg_rx_use),
    .rx_size              (rx_size_c),
    .tx_size              (tx_size_c),
    .rx_limit             (rx_limit_c)
  );

  // Registered so the FIFO sees glitch-free sizes; one cycle of lag is harmless
  // because software clears the FIFOs after changing the split
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      rx_size_ff  <= sfc_pkg::SIZE_NONE;
      tx_size_ff  <= sfc_pkg::SIZE_NONE;
      rx_limit_ff <= sfc_pkg::SIZE_NONE;
    end else begin
      rx_size_ff  <= rx_size_c;
      tx_size_ff  <= tx_size_c;
      rx_limit_ff <= rx_limit_c;
    end
  end

  // ==========================================================
  // Interrupt gating
  // With the FIFO off the plain buffer requests pass untouched; with it on
  // only the FIFO requests pass, each behind its own enable

  wire logic tx_irq_c = cfg_fifo_en ? (tx_fifo_irq_req & cfg_tx_irqen) : tx_buf_irq_req;
  wire logic rx_irq_c = cfg_fifo_en ? (rx_fifo_irq_req & cfg_rx_irqen) : rx_buf_irq_req;

  // Registered interrupt lines
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      tx_irq_ff <= 1'b0;
      rx_irq_ff <= 1'b0;
    end else begin
      tx_irq_ff <= tx_irq_c;
      rx_irq_ff <= rx_irq_c;
    end
  end

  // ==========================================================
  // Automatic disable conditions

  wire logic mode_half_rx = (duplex == sfc_pkg::DPX_HALF_RX);
  wire logic mode_half_tx = (duplex == sfc_pkg::DPX_HALF_TX);
  wire logic mode_full    = (duplex == sfc_pkg::DPX_FULL);

  wire logic rx_all_full  = rx_shift_full & rx_buf_full & rx_fifo_full;
  wire logic tx_all_empty = tx_fifo_empty & tx_buf_empty & tx_shift_empty;

  // Which enables a stop drops in each mode
  wire logic want_rx_stop = cfg_auto_dis & ((mode_half_rx & rx_all_full) |
                                            (mode_full & (rx_all_full | tx_all_empty)));
  wire logic want_tx_stop = cfg_auto_dis & ((mode_half_tx & tx_all_empty) |
                                            (mode_full & (rx_all_full | tx_all_empty)));

  // A stop only matters while the enable it targets is still set
  wire logic trig_rx = want_rx_stop & rx_enable;
  wire logic trig_tx = want_tx_stop & tx_enable;
  wire logic trig    = trig_rx | trig_tx;

  // Stop has taken effect once no targeted enable remains set
  wire logic stop_done = ~(want_rx_stop & rx_enable) & ~(want_tx_stop & tx_enable);

  // ==========================================================
  // Auto disable sequencer
  // IDLE waits for a stop, CLEAR issues the one-cycle requests, HOLD waits
  // for the enables to fall so the same stop is not requested twice.
  // Turning auto disable off always returns to IDLE

  always_comb begin
    nxt_ad_state = ad_state_ff;
    case (ad_state_ff)
      sfc_pkg::SFC_AD_IDLE: begin
        if (trig) begin
          nxt_ad_state = sfc_pkg::SFC_AD_CLEAR;
        end
      end
      sfc_pkg::SFC_AD_CLEAR: begin
        nxt_ad_state = sfc_pkg::SFC_AD_HOLD;
      end
      sfc_pkg::SFC_AD_HOLD: begin
        if (stop_done || !cfg_auto_dis) begin
          nxt_ad_state = sfc_pkg::SFC_AD_IDLE;
        end
      end
      default: begin
        nxt_ad_state = sfc_pkg::SFC_AD_IDLE;
      end
    endcase
    if (!cfg_auto_dis) begin
      nxt_ad_state = sfc_pkg::SFC_AD_IDLE;
    end
  end

  // State and clear requests; requests only leave IDLE on a live trigger
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      ad_state_ff <= sfc_pkg::SFC_AD_IDLE;
      rx_clr_ff   <= 1'b0;
      tx_clr_ff   <= 1'b0;
    end else begin
      ad_state_ff <= nxt_ad_state;
      rx_clr_ff   <= (ad_state_ff == sfc_pkg::SFC_AD_IDLE) & trig_rx;
      tx_clr_ff   <= (ad_state_ff == sfc_pkg::SFC_AD_IDLE) & trig_tx;
    end
  end

  // ==========================================================
  // Event status and summary interrupt

  wire logic [sfc_pkg::NUM_EV-1:0] ev_set;
  wire logic [sfc_pkg::NUM_EV-1:0] ev_status;
  wire logic [sfc_pkg::NUM_EV-1:0] ev_mask;

  assign ev_set[sfc_pkg::EV_RX_STOP] = rx_clr_ff;
  assign ev_set[sfc_pkg::EV_TX_STOP] = tx_clr_ff;
  assign ev_set[sfc_pkg::EV_TX_FIFO] = cfg_fifo_en & tx_fifo_irq_req & cfg_tx_irqen;
  assign ev_set[sfc_pkg::EV_RX_FIFO] = cfg_fifo_en & rx_fifo_irq_req & cfg_rx_irqen;

  sfc_event_regs u_events (
    .ref_clk   (ref_clk),
    .rstn      (rstn),
    .event_set (ev_set),
    .status_wr (wr_ists),
    .mask_wr   (wr_imsk),
    .wdata     (reg_wdata[sfc_pkg::NUM_EV-1:0]),
    .status    (ev_status),
    .mask      (ev_mask),
    .irq       (irq)
  );

  // ==========================================================
  // Read path
  // Unmapped addresses and unused upper bits read as zero

  always_comb begin
    nxt_rdata = 32'h0000_0000;
    if (hit_fcnf) begin
      nxt_rdata[7:0] = fcnf_ff;
    end else if (hit_ists) begin
      nxt_rdata[sfc_pkg::NUM_EV-1:0] = ev_status;
    end else if (hit_imsk) begin
      nxt_rdata[sfc_pkg::NUM_EV-1:0] = ev_mask;
    end else if (hit_state) begin
      nxt_rdata[2:0]  = rx_size_ff;
      nxt_rdata[6:4]  = tx_size_ff;
      nxt_rdata[10:8] = rx_limit_ff;
      nxt_rdata[14:12] = ad_state_ff;
    end
  end

  // Data stand only in the cycle after the read strobe
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      rdata_ff <= 32'h0000_0000;
    end else begin
      rdata_ff <= reg_rd ? nxt_rdata : 32'h0000_0000;
    end
  end

  // ==========================================================
  // Outputs

  assign reg_rdata       = rdata_ff;
  assign fifo_en         = cfg_fifo_en;
  assign rx_fifo_size    = rx_size_ff;
  assign tx_fifo_size    = tx_size_ff;
  assign rx_fifo_limit   = rx_limit_ff;
  assign tx_irq          = tx_irq_ff;
  assign rx_irq          = rx_irq_ff;
  assign rx_enable_clear = rx_clr_ff;
  assign tx_enable_clear = tx_clr_ff;

endmodule

/* sfc_fifo_config_asserts.sv */
/*
  Checker of sfc_fifo_config: sizing, gating, reads, enable clears.
  Assumes one ref_clk domain; bound below.
*/
`timescale 1ns/100ps
module sfc_fifo_config_asserts (
  input wire logic        ref_clk,
  input wire logic        rstn,
  input wire logic [7:0]  reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [31:0] reg_rdata,
  input wire logic [1:0]  duplex,
  input wire logic [1:0]  rx_fill_code,
  input wire logic        rx_enable,
  input wire logic        tx_enable,
  input wire logic        rx_shift_full,
  input wire logic        rx_buf_full,
  input wire logic        rx_fifo_full,
  input wire logic        tx_fifo_empty,
  input wire logic        tx_buf_empty,
  input wire logic        tx_shift_empty,
  input wire logic        tx_fifo_irq_req,
  input wire logic        rx_fifo_irq_req,
  input wire logic        tx_buf_irq_req,
  input wire logic        rx_buf_irq_req,
  input wire logic        fifo_en,
  input wire logic [2:0]  rx_fifo_size,
  input wire logic [2:0]  tx_fifo_size,
  input wire logic [2:0]  rx_fifo_limit,
  input wire logic        tx_irq,
  input wire logic        rx_irq,
  input wire logic        rx_enable_clear,
  input wire logic        tx_enable_clear
);
  // ==========
  // Shadow of the configuration byte
  logic [7:0] cfg_ff;
  wire        wr_cfg = reg_wr && reg_addr == sfc_pkg::ADDR_FCNF;
  always_ff @(posedge ref_clk) begin
    if (!rstn)
      cfg_ff <= 8'h00;
    else if (wr_cfg)
      cfg_ff <= reg_wdata[7:0];
  end

  // Expected values from present settings; outputs lag them by one cycle
  wire       hrx     = duplex == sfc_pkg::DPX_HALF_RX;
  wire       htx     = duplex == sfc_pkg::DPX_HALF_TX;
  wire       fdx     = duplex == sfc_pkg::DPX_FULL;
  wire       rx_all  = rx_shift_full & rx_buf_full & rx_fifo_full;
  wire       tx_all  = tx_fifo_empty & tx_buf_empty & tx_shift_empty;
  wire       rx_trig = cfg_ff[1] & rx_enable & ((hrx & rx_all) | (fdx & (rx_all | tx_all)));
  wire       tx_trig = cfg_ff[1] & tx_enable & ((htx & tx_all) | (fdx & (rx_all | tx_all)));
  wire [2:0] exp_rxs = !cfg_ff[0] ? 3'h0 : hrx ? 3'h4 : fdx ? 3'h2 : 3'h0;
  wire [2:0] exp_txs = !cfg_ff[0] ? 3'h0 : htx ? 3'h4 : fdx ? 3'h2 : 3'h0;
  wire [2:0] fill    = fdx ? (rx_fill_code[0] ? 3'h1 : 3'h2) :
                       (rx_fill_code == 2'h0 ? 3'h4 : {1'b0, rx_fill_code});
  wire [2:0] exp_lim = (cfg_ff[4] && exp_rxs != 3'h0) ? fill : exp_rxs;
  wire       exp_txi = cfg_ff[0] ? tx_fifo_irq_req & cfg_ff[3] : tx_buf_irq_req;
  wire       exp_rxi = cfg_ff[0] ? rx_fifo_irq_req & cfg_ff[2] : rx_buf_irq_req;

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rstn);

  // ==========
  // Properties
  cfg_enable_a: assert property (wr_cfg |=> fifo_en == $past(reg_wdata[0]))
    else $error("fifo enable not taken from bit 0");
  fifo_size_a: assert property (1'b1 |=> rx_fifo_size == $past(exp_rxs) && tx_fifo_size == $past(exp_txs))
    else $error("fifo sizes wrong");
  rx_limit_a: assert property (1'b1 |=> rx_fifo_limit == $past(exp_lim))
    else $error("receive limit wrong");
  irq_gate_a: assert property (1'b1 |=> tx_irq == $past(exp_txi) && rx_irq == $past(exp_rxi))
    else $error("interrupt gating wrong");
  rd_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
    else $error("read data outside its cycle");
  cfg_read_a: assert property ($past(reg_rd && reg_addr == sfc_pkg::ADDR_FCNF) |-> reg_rdata == {24'h0, $past(cfg_ff)})
    else $error("configuration read back wrong");
  rx_cause_a: assert property (rx_enable_clear |-> $past(rx_trig))
    else $error("receive enable cleared without cause");
  tx_cause_a: assert property (tx_enable_clear |-> $past(tx_trig))
    else $error("transmit enable cleared without cause");
  rx_stop_a: assert property (hrx && $rose(rx_trig) |-> ##[1:3] rx_enable_clear)
    else $error("receive stop missing");
  tx_stop_a: assert property (htx && $rose(tx_trig) |-> ##[1:3] tx_enable_clear)
    else $error("transmit stop missing");
  clr_pulse_a: assert property ((rx_enable_clear || tx_enable_clear) |=> !(rx_enable_clear || tx_enable_clear))
    else $error("clear request longer than one cycle");
  fdx_pair_a: assert property ((rx_enable_clear || tx_enable_clear) && $past(fdx && rx_enable && tx_enable)
    |-> rx_enable_clear && tx_enable_clear)
    else $error("full duplex stop not paired");

  cover property (rx_enable_clear && tx_enable_clear);
  cover property (tx_irq && fifo_en);
  cover property (rx_fifo_limit == 3'h3);
endmodule

bind sfc_fifo_config sfc_fifo_config_asserts chk_i (
  .ref_clk, .rstn, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .duplex, .rx_fill_code,
  .rx_enable, .tx_enable, .rx_shift_full, .rx_buf_full, .rx_fifo_full, .tx_fifo_empty, .tx_buf_empty,
  .tx_shift_empty, .tx_fifo_irq_req, .rx_fifo_irq_req, .tx_buf_irq_req, .rx_buf_irq_req, .fifo_en,
  .rx_fifo_size, .tx_fifo_size, .rx_fifo_limit, .tx_irq, .rx_irq, .rx_enable_clear, .tx_enable_clear
);

/* sfc_chan_model.sv */
/*
  Channel side model: holds the receive and transmit enables.
  Assumes clear requests are one-cycle pulses on ref_clk.
*/
`timescale 1ns/100ps
module sfc_chan_model (
  input  wire logic ref_clk,
  input  wire logic rstn,
  input  wire logic rx_enable_clear,
  input  wire logic tx_enable_clear,
  input  wire logic set_rx,
  input  wire logic set_tx,
  input  wire logic slow,
  output logic      rx_enable,
  output logic      tx_enable
);
  logic rx_en_ff;
  logic tx_en_ff;
  logic rx_late_ff;
  logic tx_late_ff;
  assign rx_enable = rx_en_ff;
  assign tx_enable = tx_en_ff;

  // ==========
  // Enable holding; slow mode drops one cycle late, as a busy channel may
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      rx_en_ff   <= 1'b0;
      tx_en_ff   <= 1'b0;
      rx_late_ff <= 1'b0;
      tx_late_ff <= 1'b0;
    end else begin
      rx_late_ff <= rx_enable_clear & slow;
      tx_late_ff <= tx_enable_clear & slow;
      if ((rx_enable_clear & !slow) | rx_late_ff)
        rx_en_ff <= 1'b0;
      else if (set_rx)
        rx_en_ff <= 1'b1;
      if ((tx_enable_clear & !slow) | tx_late_ff)
        tx_en_ff <= 1'b0;
      else if (set_tx)
        tx_en_ff <= 1'b1;
    end
  end
endmodule

/* testbench.sv */
/*
  Self-checking bench of sfc_fifo_config with the channel model.
  Assumes the checker file binds itself to the design.
*/
`timescale 1ns/100ps
module testbench;
  logic        ref_clk, rstn, reg_wr, reg_rd, irq;
  logic [7:0]  reg_addr;
  logic [31:0] reg_wdata, reg_rdata, d;
  logic [1:0]  duplex, rx_fill_code;
  logic        rx_enable, tx_enable, set_rx, set_tx, slow, tx_irq, rx_irq;
  logic        rx_enable_clear, tx_enable_clear;
  logic [2:0]  rfl, tfl;
  logic [3:0]  req;
  logic [7:0]  c;
  logic        pend = 1'b0;
  logic [31:0] exp_q[$];
  int          failures = 0;
  int          total_checks = 0;

  sfc_fifo_config dut (
    .ref_clk, .rstn, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .duplex, .rx_fill_code, .rx_enable, .tx_enable,
    .rx_shift_full(rfl[2]), .rx_buf_full(rfl[1]), .rx_fifo_full(rfl[0]),
    .tx_fifo_empty(tfl[2]), .tx_buf_empty(tfl[1]), .tx_shift_empty(tfl[0]),
    .tx_fifo_irq_req(req[3]), .rx_fifo_irq_req(req[2]), .tx_buf_irq_req(req[1]), .rx_buf_irq_req(req[0]),
    .fifo_en(), .rx_fifo_size(), .tx_fifo_size(), .rx_fifo_limit(),
    .tx_irq, .rx_irq, .rx_enable_clear, .tx_enable_clear, .irq
  );
  sfc_chan_model chan (
    .ref_clk, .rstn, .rx_enable_clear, .tx_enable_clear, .set_rx, .set_tx, .slow, .rx_enable, .tx_enable
  );

  // ==========
  // Checking and closing
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic end_of_test;
    $display("checks=%0d failures=%0d", total_checks, failures);
    if (failures == 0 && total_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // One bus cycle; a read queues its expected word
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] v);
    @(posedge ref_clk);
    reg_addr  <= a;
    reg_wdata <= v;
    reg_wr    <= w;
    reg_rd    <= !w;
    if (!w)
      exp_q.push_back(v);
    @(posedge ref_clk);
    reg_wr <= 1'b0;
    reg_rd <= 1'b0;
  endtask

  // Expected sizing word of the state register
  function automatic logic [31:0] exp_state(input logic [7:0] cf, input logic [1:0] dx, input logic [1:0] f);
    logic [2:0] r, t, l;
    r = !cf[0] ? 3'h0 : dx == sfc_pkg::DPX_HALF_RX ? 3'h4 : dx == sfc_pkg::DPX_FULL ? 3'h2 : 3'h0;
    t = !cf[0] ? 3'h0 : dx == sfc_pkg::DPX_HALF_TX ? 3'h4 : dx == sfc_pkg::DPX_FULL ? 3'h2 : 3'h0;
    l = r;
    if (cf[4] && r != 3'h0)
      l = dx == sfc_pkg::DPX_FULL ? (f[0] ? 3'h1 : 3'h2) : (f == 2'h0 ? 3'h4 : {1'b0, f});
    return {17'h0, sfc_pkg::SFC_AD_IDLE, 1'b0, l, 1'b0, t, 1'b0, r};
  endfunction

  // Read data stand one cycle after the strobe
  always @(posedge ref_clk) begin
    pend <= reg_rd;
    if (pend && exp_q.size() > 0)
      chk(reg_rdata, exp_q.pop_front());
  end

  initial begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end

  // Whole run needs about 500 cycles
  initial begin
    repeat (6000) @(posedge ref_clk);
    failures++;
    end_of_test();
  end

  // ==========
  // No 9-bit or DMA use; duplex is set before the enable
  initial begin
    {rstn, reg_wr, reg_rd, reg_addr, reg_wdata, duplex, rx_fill_code} = '0;
    {rfl, tfl, req, set_rx, set_tx, slow} = '0;
    void'($urandom(3266));
    repeat (12) @(posedge ref_clk);
    rstn <= 1'b1;
    bus(1'b0, sfc_pkg::ADDR_FCNF, 32'h0);
    bus(1'b0, sfc_pkg::ADDR_IMSK, 32'h0);
    bus(1'b1, 8'h14, 32'hFFFFFFFF);
    bus(1'b0, 8'h14, 32'h0);
    d = $urandom;
    bus(1'b1, sfc_pkg::ADDR_FCNF, d);
    bus(1'b0, sfc_pkg::ADDR_FCNF, {24'h0, d[7:0]});
    // Every duplex, fill code, usage select and enable combination
    for (int i = 0; i < 64; i++) begin
      d = $urandom;
      c = {d[7:5], i[5], 3'h0, i[4]};
      duplex <= i[3:2];
      rx_fill_code <= i[1:0];
      bus(1'b1, sfc_pkg::ADDR_FCNF, {24'h0, c});
      bus(1'b0, sfc_pkg::ADDR_STATE, exp_state(c, i[3:2], i[1:0]));
    end
    // Interrupt gating with random raw requests
    for (int i = 0; i < 16; i++) begin
      d = $urandom;
      c = {4'h0, i[1:0], 1'b0, i[2]};
      req <= d[3:0];
      bus(1'b1, sfc_pkg::ADDR_FCNF, {24'h0, c});
      repeat (2) @(posedge ref_clk);
      chk(tx_irq, c[0] ? d[3] & c[3] : d[1]);
      chk(rx_irq, c[0] ? d[2] & c[2] : d[0]);
    end
    // Sticky event, mask and write-one-to-clear
    req <= 4'h0;
    bus(1'b1, sfc_pkg::ADDR_FCNF, 32'h0D);
    bus(1'b1, sfc_pkg::ADDR_ISTS, 32'hF);
    bus(1'b0, sfc_pkg::ADDR_ISTS, 32'h0);
    req <= 4'h8;
    @(posedge ref_clk);
    req <= 4'h0;
    bus(1'b1, sfc_pkg::ADDR_IMSK, 32'h3);
    chk(irq, 1'b0);
    bus(1'b1, sfc_pkg::ADDR_IMSK, 32'h4);
    @(posedge ref_clk);
    chk(irq, 1'b1);
    bus(1'b0, sfc_pkg::ADDR_ISTS, 32'h4);
    bus(1'b1, sfc_pkg::ADDR_ISTS, 32'h4);
    @(posedge ref_clk);
    chk(irq, 1'b0);
    bus(1'b1, sfc_pkg::ADDR_IMSK, 32'h3);
    // Automatic disable in each duplex mode, with and without the bit
    for (int i = 0; i < 8; i++) begin
      d = $urandom;
      rfl <= 3'h0;
      tfl <= 3'h0;
      slow <= d[8];
      duplex <= i[1:0] == 2'h0 ? sfc_pkg::DPX_HALF_RX : i[1:0] == 2'h1 ? sfc_pkg::DPX_HALF_TX : sfc_pkg::DPX_FULL;
      bus(1'b1, sfc_pkg::ADDR_FCNF, {30'h0, i[2], 1'b1});
      set_rx <= 1'b1;
      set_tx <= 1'b1;
      @(posedge ref_clk);
      set_rx <= 1'b0;
      set_tx <= 1'b0;
      @(posedge ref_clk);
      rfl <= i[1:0] != 2'h3 ? 3'h7 : d[2:0] ^ {2'h0, &d[2:0]};
      tfl <= i[1:0] != 2'h2 ? 3'h7 : d[6:4] ^ {2'h0, &d[6:4]};
      repeat (8) @(posedge ref_clk);
      chk(rx_enable, !(i[2] && i[1:0] != 2'h1));
      chk(tx_enable, !(i[2] && i[1:0] != 2'h0));
      chk(irq, i[2]);
      bus(1'b0, sfc_pkg::ADDR_ISTS, {30'h0, i[2] && i[1:0] != 2'h0, i[2] && i[1:0] != 2'h1});
      bus(1'b1, sfc_pkg::ADDR_ISTS, 32'h3);
    end
    repeat (3) @(posedge ref_clk);
    end_of_test();
  end
endmodule
